// ==== uisc_pkg.sv ====
// How it works
// - Raw pending register at 0x3C, read-only, one per source, resets to zero.
// - Raw bits: CTS change 1, receive 4, transmit 5, receive timeout 6.
// - Raw error bits: framing 7, parity 8, break 9, overrun 10.
// - Raw bits: flow stop character 11, transmit FIFO empty 12.
// - Masked pending register at 0x40 shows enabled pending sources only.
// - Masked error bits 7 to 10, reset zero, set while enabled and pending.
// - Masked bits 11 and 12; bits 31 to 13 read zero.
// - Clear register at 0x44, write-only; a 1 clears that source's pending state unless its event arrives in the same cycle.
// - A 0 in the clear register leaves the source unchanged.
// - Clear bits use the same positions, bit 1 and bits 4 through 12.
// - Enable mask register at 0x38, read-write, 1 enables, resets all disabled.
package uisc_pkg;
  localparam int unsigned UISC_AW = 8;
  localparam int unsigned UISC_DW = 32;
  localparam int unsigned UISC_NSRC = 13;
  localparam logic [7:0] UISC_OFS_MASK = 8'h38;
  localparam logic [7:0] UISC_OFS_RAW = 8'h3C;
  localparam logic [7:0] UISC_OFS_MASKED = 8'h40;
  localparam logic [7:0] UISC_OFS_CLEAR = 8'h44;
  localparam int unsigned UISC_BIT_CTS = 1;
  localparam int unsigned UISC_BIT_RX = 4;
  localparam int unsigned UISC_BIT_TX = 5;
  localparam int unsigned UISC_BIT_RTO = 6;
  localparam int unsigned UISC_BIT_FE = 7;
  localparam int unsigned UISC_BIT_PE = 8;
  localparam int unsigned UISC_BIT_BRK = 9;
  localparam int unsigned UISC_BIT_OVR = 10;
  localparam int unsigned UISC_BIT_XOFF = 11;
  localparam int unsigned UISC_BIT_TXFE = 12;
  // Implemented source bits: 1, 4..12
  localparam logic [12:0] UISC_SRC_MASK = 13'h1FF2;
  localparam logic [12:0] UISC_RST_PEND = 13'h0000;
  localparam logic [12:0] UISC_RST_MASK = 13'h0000;
  localparam logic [31:0] UISC_RD_RST = 32'h0000_0000;
endpackage : uisc_pkg

// ==== uisc_pend_bit.sv ====
`timescale 1ns/1ps
`default_nettype none
module uisc_pend_bit (
  input wire logic i_ref_clk, // Clock
  input wire logic i_nrst, // Async reset, low
  input wire logic i_event, // Source event, one cycle
  input wire logic i_clr, // Software clear pulse
  output logic o_pend // Pending flag
);
  logic pend_r;
  logic pend_nxt;

  // Set beats clear; a 0 clear leaves state alone
  always_comb begin
    pend_nxt = pend_r;
    if (i_clr) begin
      pend_nxt = 1'b0;
    end
    if (i_event) begin
      pend_nxt = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign o_pend = pend_r;
endmodule : uisc_pend_bit
`default_nettype wire

// ==== uisc_top.sv ====
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uisc_top
  import uisc_pkg::*;
(
  input wire logic i_ref_clk, // 20 MHz clock
  input wire logic i_nrst, // Async reset, low
  input wire logic [uisc_pkg::UISC_AW-1:0] i_addr, // Byte address
  input wire logic [uisc_pkg::UISC_DW-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [uisc_pkg::UISC_NSRC-1:0] i_event, // Source event pulses
  output logic [uisc_pkg::UISC_DW-1:0] o_rdata, // Read data, next cycle
  output logic [uisc_pkg::UISC_NSRC-1:0] o_raw_pend, // Raw pending view
  output logic o_irq // Combined interrupt
);
  import uisc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode results
  logic hit_mask;
  logic hit_raw;
  logic hit_masked;
  logic hit_clear;

  // Qualified access strobes
  logic wr_mask;
  logic wr_clear;
  logic rd_mask;
  logic rd_raw;
  logic rd_masked;

  // Source vectors, bit n belongs to status bit n
  logic [UISC_NSRC-1:0] evt;
  logic [UISC_NSRC-1:0] pend;
  logic [UISC_NSRC-1:0] pend_ahead;
  logic [UISC_NSRC-1:0] masked;
  logic [UISC_NSRC-1:0] clr_pulse;

  // Enable mask state
  logic [UISC_NSRC-1:0] mask_r;
  logic [UISC_NSRC-1:0] mask_nxt;

  // Clear strobes by source
  logic cts_change_clear;
  logic receive_clear;
  logic transmit_clear;
  logic receive_timeout_clear;
  logic framing_error_clear;
  logic parity_error_clear;
  logic break_clear;
  logic overrun_clear;
  logic flow_stop_char_clear;
  logic tx_fifo_empty_clear;

  // Raw pending by source
  logic cts_change_raw;
  logic receive_raw;
  logic transmit_raw;
  logic receive_timeout_raw;
  logic framing_error_raw;
  logic parity_error_raw;
  logic break_raw;
  logic overrun_raw;
  logic flow_stop_char_raw;
  logic tx_fifo_empty_raw;

  // Masked pending by source
  logic cts_change_masked;
  logic receive_masked;
  logic transmit_masked;
  logic receive_timeout_masked;
  logic framing_error_masked;
  logic parity_error_masked;
  logic break_masked;
  logic overrun_masked;
  logic flow_stop_char_masked;
  logic tx_fifo_empty_masked;

  // Assembled read words
  logic [UISC_DW-1:0] mask_word;
  logic [UISC_DW-1:0] raw_word;
  logic [UISC_DW-1:0] masked_word;

  // Read data register
  logic [UISC_DW-1:0] rdata_r;
  logic [UISC_DW-1:0] rdata_nxt;

  // Interrupt register
  logic irq_r;
  logic irq_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Exact match on the byte address; any other offset is unmapped
  assign hit_mask = (i_addr == UISC_OFS_MASK);
  assign hit_raw = (i_addr == UISC_OFS_RAW);
  assign hit_masked = (i_addr == UISC_OFS_MASKED);
  assign hit_clear = (i_addr == UISC_OFS_CLEAR);

  // Writes to the two status offsets match nothing and are dropped
  assign wr_mask = i_wr && hit_mask;
  assign wr_clear = i_wr && hit_clear;

  // Reads; the clear offset has no read strobe and so returns zero
  assign rd_mask = i_rd && hit_mask;
  assign rd_raw = i_rd && hit_raw;
  assign rd_masked = i_rd && hit_masked;

  ////////////////////////////////////////////////////////////////////////////
  // Pulses on reserved positions never reach a flag
  assign evt = i_event & UISC_SRC_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Each one in the clear word strobes its source for one cycle
  // Line status sources
  assign cts_change_clear = wr_clear && i_wdata[UISC_BIT_CTS];
  assign receive_clear = wr_clear && i_wdata[UISC_BIT_RX];
  assign transmit_clear = wr_clear && i_wdata[UISC_BIT_TX];
  assign receive_timeout_clear = wr_clear && i_wdata[UISC_BIT_RTO];
  // Receive error sources
  assign framing_error_clear = wr_clear && i_wdata[UISC_BIT_FE];
  assign parity_error_clear = wr_clear && i_wdata[UISC_BIT_PE];
  assign break_clear = wr_clear && i_wdata[UISC_BIT_BRK];
  assign overrun_clear = wr_clear && i_wdata[UISC_BIT_OVR];
  // Flow control and FIFO sources
  assign flow_stop_char_clear = wr_clear && i_wdata[UISC_BIT_XOFF];
  assign tx_fifo_empty_clear = wr_clear && i_wdata[UISC_BIT_TXFE];

  // Strobes back in status bit order; a zero bit gives no strobe
  always_comb begin
    clr_pulse = '0;
    // Line status sources
    clr_pulse[UISC_BIT_CTS] = cts_change_clear;
    clr_pulse[UISC_BIT_RX] = receive_clear;
    clr_pulse[UISC_BIT_TX] = transmit_clear;
    clr_pulse[UISC_BIT_RTO] = receive_timeout_clear;
    // Receive error sources
    clr_pulse[UISC_BIT_FE] = framing_error_clear;
    clr_pulse[UISC_BIT_PE] = parity_error_clear;
    clr_pulse[UISC_BIT_BRK] = break_clear;
    clr_pulse[UISC_BIT_OVR] = overrun_clear;
    // Flow control and FIFO sources
    clr_pulse[UISC_BIT_XOFF] = flow_stop_char_clear;
    clr_pulse[UISC_BIT_TXFE] = tx_fifo_empty_clear;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One pending flag per implemented source; reserved bits stay zero
  genvar g;
  generate
    for (g = 0; g < UISC_NSRC; g++) begin : g_src
      if (UISC_SRC_MASK[g]) begin : g_on
        uisc_pend_bit u_bit (
          .i_ref_clk(i_ref_clk),
          .i_nrst(i_nrst),
          .i_event(evt[g]),
          .i_clr(clr_pulse[g]),
          .o_pend(pend[g])
        );
      end else begin : g_off
        assign pend[g] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Raw flags by source
  // Line status sources
  assign cts_change_raw = pend[UISC_BIT_CTS];
  assign receive_raw = pend[UISC_BIT_RX];
  assign transmit_raw = pend[UISC_BIT_TX];
  assign receive_timeout_raw = pend[UISC_BIT_RTO];
  // Receive error sources
  assign framing_error_raw = pend[UISC_BIT_FE];
  assign parity_error_raw = pend[UISC_BIT_PE];
  assign break_raw = pend[UISC_BIT_BRK];
  assign overrun_raw = pend[UISC_BIT_OVR];
  // Flow control and FIFO sources
  assign flow_stop_char_raw = pend[UISC_BIT_XOFF];
  assign tx_fifo_empty_raw = pend[UISC_BIT_TXFE];

  // Masked view is the raw flag gated by its enable bit
  assign masked = pend & mask_r;

  // Masked flags by source
  // Line status sources
  assign cts_change_masked = masked[UISC_BIT_CTS];
  assign receive_masked = masked[UISC_BIT_RX];
  assign transmit_masked = masked[UISC_BIT_TX];
  assign receive_timeout_masked = masked[UISC_BIT_RTO];
  // Receive error sources
  assign framing_error_masked = masked[UISC_BIT_FE];
  assign parity_error_masked = masked[UISC_BIT_PE];
  assign break_masked = masked[UISC_BIT_BRK];
  assign overrun_masked = masked[UISC_BIT_OVR];
  // Flow control and FIFO sources
  assign flow_stop_char_masked = masked[UISC_BIT_XOFF];
  assign tx_fifo_empty_masked = masked[UISC_BIT_TXFE];

  ////////////////////////////////////////////////////////////////////////////
  // Enable mask word; reserved positions read zero
  always_comb begin
    mask_word = UISC_RD_RST;
    mask_word[UISC_NSRC-1:0] = mask_r;
  end

  // Raw pending word, one field per source
  always_comb begin
    raw_word = UISC_RD_RST;
    // Line status sources
    raw_word[UISC_BIT_CTS] = cts_change_raw;
    raw_word[UISC_BIT_RX] = receive_raw;
    raw_word[UISC_BIT_TX] = transmit_raw;
    raw_word[UISC_BIT_RTO] = receive_timeout_raw;
    // Receive error sources
    raw_word[UISC_BIT_FE] = framing_error_raw;
    raw_word[UISC_BIT_PE] = parity_error_raw;
    raw_word[UISC_BIT_BRK] = break_raw;
    raw_word[UISC_BIT_OVR] = overrun_raw;
    // Flow control and FIFO sources
    raw_word[UISC_BIT_XOFF] = flow_stop_char_raw;
    raw_word[UISC_BIT_TXFE] = tx_fifo_empty_raw;
  end

  // Masked pending word; bits 31 down to 13 stay zero
  always_comb begin
    masked_word = UISC_RD_RST;
    // Line status sources
    masked_word[UISC_BIT_CTS] = cts_change_masked;
    masked_word[UISC_BIT_RX] = receive_masked;
    masked_word[UISC_BIT_TX] = transmit_masked;
    masked_word[UISC_BIT_RTO] = receive_timeout_masked;
    // Receive error sources
    masked_word[UISC_BIT_FE] = framing_error_masked;
    masked_word[UISC_BIT_PE] = parity_error_masked;
    masked_word[UISC_BIT_BRK] = break_masked;
    masked_word[UISC_BIT_OVR] = overrun_masked;
    // Flow control and FIFO sources
    masked_word[UISC_BIT_XOFF] = flow_stop_char_masked;
    masked_word[UISC_BIT_TXFE] = tx_fifo_empty_masked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next enable mask; only implemented source bits are stored
  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = i_wdata[UISC_NSRC-1:0] & UISC_SRC_MASK;
    end
  end

  // Enable mask register, all sources disabled after reset
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_r <= UISC_RST_MASK;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data for the next cycle; zero whenever no read is decoded
  always_comb begin
    rdata_nxt = UISC_RD_RST;
    if (rd_mask) begin
      rdata_nxt = mask_word;
    end
    if (rd_raw) begin
      rdata_nxt = raw_word;
    end
    if (rd_masked) begin
      rdata_nxt = masked_word;
    end
  end

  // Read data register; the word stands for one cycle only
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= UISC_RD_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag state one cycle ahead, with the same set-beats-clear order as
  // each flag, so the registered interrupt changes in step with the flags
  always_comb begin
    pend_ahead = (pend & ~clr_pulse) | evt;
    irq_nxt = |(pend_ahead & mask_nxt);
  end

  // Combined interrupt register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign o_rdata = rdata_r;
  assign o_raw_pend = pend;
  assign o_irq = irq_r;
endmodule : uisc_top
`default_nettype wire

// ==== uisc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module uisc_chk
  import uisc_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic [UISC_AW-1:0] i_addr, // Address
  input wire logic [UISC_DW-1:0] i_wdata, // Data
  input wire logic i_wr, // Write
  input wire logic i_rd, // Read
  input wire logic [UISC_NSRC-1:0] i_event, // Events
  input wire logic [UISC_DW-1:0] o_rdata, // Read data
  input wire logic [UISC_NSRC-1:0] o_raw_pend, // Flags
  input wire logic o_irq // Irq
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // Clear register write
  sequence s_clr;
    i_wr && i_addr == UISC_OFS_CLEAR;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_event_sets: assert property (
    1 |=> (~o_raw_pend & $past(i_event) & UISC_SRC_MASK) == 0) else $error("event lost");
  a_unused_zero: assert property (
    (o_raw_pend & ~UISC_SRC_MASK) == 0) else $error("unused flag set");
  a_raw_read: assert property (
    i_rd && i_addr == UISC_OFS_RAW |=> o_rdata == 32'($past(o_raw_pend))) else $error("raw");
  a_masked_read: assert property (
    i_rd && i_addr == UISC_OFS_MASKED |=> (o_rdata & ~32'($past(o_raw_pend))) == 0)
    else $error("masked");
  a_masked_irq: assert property (
    i_rd && i_addr == UISC_OFS_MASKED |=> (o_rdata != 0) == $past(o_irq))
    else $error("masked word and irq disagree");
  a_clr_read: assert property (
    i_rd && i_addr == UISC_OFS_CLEAR |=> o_rdata == 0) else $error("clear readable");
  a_clear_bits: assert property (
    s_clr ##0 i_event == 0 |=> (o_raw_pend & $past(i_wdata)) == 0) else $error("not cleared");
  a_clear_keeps: assert property (
    s_clr |=> ($past(o_raw_pend) & ~$past(i_wdata) & ~o_raw_pend) == 0) else $error("lost");
  a_irq_needs_pend: assert property (
    o_irq |-> |o_raw_pend) else $error("irq without flag");
endmodule : uisc_chk
bind uisc_top uisc_chk u_chk (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_event, .o_rdata, .o_raw_pend, .o_irq);
`default_nettype wire

// ==== test_uart_interrupt_status_clear.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_uart_interrupt_status_clear;
  import uisc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, irq;
  logic [7:0] a = 8'h00;
  logic [31:0] d = 32'h0, q;
  logic [12:0] ev = 13'h0, raw;
  int mismatches = 0, cmp_count = 0;
  always #25 clk = ~clk;
  uisc_top dut (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(a), .i_wdata(d), .i_wr(wr),
    .i_rd(rd), .i_event(ev), .o_rdata(q), .o_raw_pend(raw), .o_irq(irq));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // One bus cycle, then settle
  task acc(input logic w, input logic [7:0] ad, input logic [31:0] dv);
    @(posedge clk);
    a <= ad;
    d <= dv;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : acc
  task rdc(input logic [7:0] ad, input logic [31:0] e);
    acc(1'b0, ad, 32'h0);
    chk(q, e);
  endtask : rdc
  task pulse(input logic [12:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 13'h0;
    #1;
  endtask : pulse
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(8'h38, 32'h0);
    rdc(8'h3C, 32'h0);
    rdc(8'h40, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(raw), 32'h0);
  endtask : t_reset
  task t_sources;
    for (int i = 0; i < 13; i++) begin
      pulse(13'(1 << i));
      rdc(8'h3C, 32'(UISC_SRC_MASK) & (32'h1 << i));
      rdc(8'h40, 32'h0);
      acc(1'b1, 8'h44, 32'h1 << i);
      rdc(8'h3C, 32'h0);
    end
  endtask : t_sources
  task t_mask;
    acc(1'b1, 8'h38, 32'hFFFF_FFFF);
    rdc(8'h38, 32'h0000_1FF2);
    pulse(13'h1FFF);
    rdc(8'h40, 32'h0000_1FF2);
    chk(32'(irq), 32'h1);
    acc(1'b1, 8'h44, 32'h0000_00F0);
    rdc(8'h3C, 32'h0000_1F02);
    acc(1'b1, 8'h3C, 32'h0);
    rdc(8'h40, 32'h0000_1F02);
    rdc(8'h44, 32'h0);
    rdc(8'h00, 32'h0);
    acc(1'b1, 8'h38, 32'h0000_0010);
    rdc(8'h40, 32'h0);
    chk(32'(irq), 32'h0);
    acc(1'b1, 8'h44, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0);
  endtask : t_mask
  // Event beside its own clear, strobes with no gap, reset in mid-run
  task t_race;
    pulse(13'h0030);
    @(posedge clk);
    a <= 8'h44;
    d <= 32'h0000_0030;
    wr <= 1'b1;
    ev <= 13'h0010;
    @(posedge clk);
    a <= 8'h3C;
    wr <= 1'b0;
    rd <= 1'b1;
    ev <= 13'h0000;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(32'(raw), 32'h0000_0010);
    chk(q, 32'h0000_0010);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    a <= 8'h44;
    d <= 32'h0000_0010;
    wr <= 1'b1;
    @(posedge clk);
    a <= 8'h40;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    pulse(13'h1000);
    rdc(8'h3C, 32'h0000_1000);
    @(posedge clk);
    #1;
    chk(q, 32'h0);
    acc(1'b1, 8'h38, 32'h0000_1FF2);
    pulse(13'h1FFF);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
  endtask : t_race
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Reset, then scenarios
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_sources;
    t_mask;
    t_race;
    final_report;
  end
endmodule : test_uart_interrupt_status_clear
`default_nettype wire
